/* hdl/rt_mode_pkg.sv */
package rt_mode_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] master_config_one_addr = 16'h0000;
  localparam logic [15:0] terminal_config_addr   = 16'h0017;
  localparam logic [15:0] status_bits_addr       = 16'h001a;
  localparam logic [15:0] master_config_two_addr = 16'h004e;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int start_execution_bit  = 4;
  localparam int busy_mode_bit        = 7;
  localparam int flag_test_bit        = 4;
  localparam int timeout_flag_bit     = 3;
  localparam int timeout_inhibit_bit  = 2;
  localparam int inhibit_a_bit        = 13;
  localparam int inhibit_b_bit        = 12;
  localparam int terminal_flag_bit    = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] master_config_two_reset = 16'h0000;
  localparam logic [15:0] terminal_config_reset   = 16'h0000;
  localparam logic [15:0] status_bits_reset       = 16'h0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int clk_mhz             = 25;
  localparam int tx_limit_us         = 663;
  localparam int tx_limit_cycles     = tx_limit_us * clk_mhz;
  localparam int watchdog_width      = 15;
endpackage : rt_mode_pkg

/* hdl/tx_watchdog.sv */
`timescale 1ns/10ps
`default_nettype none
module tx_watchdog #(
  parameter int limit_cycles = rt_mode_pkg::tx_limit_cycles
) (
  input  wire logic clk,      // Device clock
  input  wire logic rst,      // Synchronous reset
  input  wire logic tx_busy,  // Transmitter active
  output var  logic tx_cut,   // Force transmitter off
  output var  logic timeout   // One-cycle timeout pulse
);
  logic [rt_mode_pkg::watchdog_width-1:0] count;
  logic [rt_mode_pkg::watchdog_width-1:0] last;
  logic                                   hit;

  // Limit reached while still sending
  assign last = limit_cycles[rt_mode_pkg::watchdog_width-1:0] - 1'b1;
  assign hit  = tx_busy && !tx_cut && (count == last);

  // Counts each transmission; cut holds until the transmitter lets go
  always_ff @(posedge clk) begin
    if (rst) begin
      count   <= '0;
      tx_cut  <= 1'b0;
      timeout <= 1'b0;
    end else begin
      timeout <= hit;
      if (!tx_busy) begin
        count  <= '0;
        tx_cut <= 1'b0;
      end else if (hit) begin
        tx_cut <= 1'b1;
      end else if (!tx_cut) begin
        count <= count + 1'b1;
      end
    end
  end

  // Cut only after a full limit of one transmission
  property p_cut_len;
    @(posedge clk) disable iff (rst) $rose(tx_cut) |-> ($past(tx_busy) && $past(count) == last);
  endproperty
  a_cut_len: assert property (p_cut_len) else $error("cut without full limit");
endmodule : tx_watchdog
`default_nettype wire

/* hdl/busy_responder.sv */
`timescale 1ns/10ps
`default_nettype none
module busy_responder (
  input  wire logic clk,            // Device clock
  input  wire logic rst,            // Synchronous reset
  input  wire logic busy_mode,      // Busy-response mode active
  input  wire logic cmd_valid,      // Valid command pulse
  input  wire logic cmd_own,        // Command carries own address
  input  wire logic cmd_broadcast,  // Command is broadcast
  input  wire logic flag_in,        // Combined terminal flag
  input  wire logic busy_in,        // Normal busy bit
  output var  logic resp_start,     // Start status response pulse
  output var  logic resp_busy,      // Busy bit in status word
  output var  logic resp_flag,      // Terminal flag in status word
  output var  logic data_enable,    // Data words may follow
  output var  logic log_enable      // Interrupts and logging allowed
);
  logic answer;

  // Respond to own-address, non-broadcast commands
  assign answer = cmd_valid && cmd_own && !cmd_broadcast;

  // Status word fields latched at command time
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_start  <= 1'b0;
      resp_busy   <= 1'b0;
      resp_flag   <= 1'b0;
      data_enable <= 1'b0;
      log_enable  <= 1'b0;
    end else begin
      resp_start <= answer;
      if (answer) begin
        resp_busy   <= busy_mode || busy_in;
        resp_flag   <= flag_in;
        data_enable <= !busy_mode;
        log_enable  <= !busy_mode;
      end
    end
  end
endmodule : busy_responder
`default_nettype wire

/* hdl/rt_mode_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Busy mode and status bit set when mode pin high at reset release
// - In busy mode answer own-address valid commands at once, busy bit set
// - In busy mode send status word only, no data words
// - In busy mode no interrupts and no message logging
// - Busy answers given even during self-test or initialization
// - Host writing one to status bit leaves busy mode
// - Host writing start-execution bit leaves busy mode too
// - Mode pin low leaves busy mode
// - Bits 6 and 5 read zero
// - Bits 1 and 0 read zero
// - Flag test bit forces terminal flag in non-broadcast status words
// - Timeout with flag enable sets terminal flag status bit
// - Timeout with inhibit enable blocks that bus afterwards
// - Bus A timeout sets bus A transmit inhibit bit 13
// - Bus B timeout sets bus B transmit inhibit bit 12
// - Without inhibit enable timeout only cuts current transmission
// - Each bus watchdog limits one transmission to 663 us
module rt_mode_ctrl (
  input  wire logic        clk,             // Device clock, 25 MHz
  input  wire logic        rst,             // Synchronous reset
  input  wire logic        master_reset_n,  // Master reset pin
  input  wire logic        mode_pin,        // Busy-response mode pin
  input  wire logic        wr_en,           // Host write strobe
  input  wire logic        rd_en,           // Host read strobe
  input  wire logic [15:0] addr,            // Host register address
  input  wire logic [15:0] wdata,           // Host write data
  output var  logic [15:0] rdata,           // Host read data
  input  wire logic        cmd_valid,       // Valid command pulse
  input  wire logic        cmd_own,         // Own address matched
  input  wire logic        cmd_broadcast,   // Broadcast command
  input  wire logic        busy_in,         // Normal busy bit
  input  wire logic        tx_busy_a,       // Bus A transmitting
  input  wire logic        tx_busy_b,       // Bus B transmitting
  output logic             tx_cut_a,        // Bus A transmission cut
  output logic             tx_cut_b,        // Bus B transmission cut
  output var  logic        tx_allow_a,      // Bus A may transmit
  output var  logic        tx_allow_b,      // Bus B may transmit
  output logic             resp_start,      // Start status response
  output logic             resp_busy,       // Busy bit in status
  output logic             resp_flag,       // Terminal flag in status
  output logic             data_enable,     // Data words allowed
  output logic             log_enable       // Logging allowed
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] mr_sync;
  logic [1:0] pin_sync;
  logic       mr_prev;
  logic       mr_rise;

  // Two flops each; only the second stage is read
  // Master reset stages start at its idle high level, so no false edge follows rst
  always_ff @(posedge clk) begin
    if (rst) begin
      mr_sync  <= 2'h3;
      pin_sync <= 2'h0;
      mr_prev  <= 1'b1;
    end else begin
      mr_sync  <= {mr_sync[0], master_reset_n};
      pin_sync <= {pin_sync[0], mode_pin};
      mr_prev  <= mr_sync[1];
    end
  end

  assign mr_rise = mr_sync[1] && !mr_prev;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic sel_two;
  logic sel_one;
  logic sel_cfg;
  logic sel_sw;
  logic wr_two;
  logic wr_start;
  logic wr_exit;

  assign sel_two  = (addr == rt_mode_pkg::master_config_two_addr);
  assign sel_one  = (addr == rt_mode_pkg::master_config_one_addr);
  assign sel_cfg  = (addr == rt_mode_pkg::terminal_config_addr);
  assign sel_sw   = (addr == rt_mode_pkg::status_bits_addr);
  assign wr_two   = wr_en && sel_two;
  assign wr_start = wr_en && sel_one && wdata[rt_mode_pkg::start_execution_bit];
  assign wr_exit  = wr_two && wdata[rt_mode_pkg::busy_mode_bit];

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  logic        busy_mode;
  logic        flag_test;
  logic        timeout_flag_en;
  logic        timeout_inh_en;
  logic [15:0] term_cfg;
  logic [15:0] status_bits;
  logic        timeout_a;
  logic        timeout_b;
  logic        any_timeout;
  logic        set_inh_a;
  logic        set_inh_b;
  logic        set_flag;
  logic        flag_comb;

  assign any_timeout = timeout_a || timeout_b;
  assign set_inh_a   = timeout_a && timeout_inh_en;
  assign set_inh_b   = timeout_b && timeout_inh_en;
  assign set_flag    = any_timeout && timeout_flag_en;

  // Busy mode: entry at reset release, three exits, reset entry wins
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_mode <= 1'b0;
    end else if (mr_rise) begin
      busy_mode <= pin_sync[1];
    end else if (wr_exit || wr_start || !pin_sync[1]) begin
      busy_mode <= 1'b0;
    end
  end

  // Mode control bits of the low byte
  always_ff @(posedge clk) begin
    if (rst || !mr_sync[1]) begin
      flag_test       <= rt_mode_pkg::master_config_two_reset[rt_mode_pkg::flag_test_bit];
      timeout_flag_en <= rt_mode_pkg::master_config_two_reset[rt_mode_pkg::timeout_flag_bit];
      timeout_inh_en  <= rt_mode_pkg::master_config_two_reset[rt_mode_pkg::timeout_inhibit_bit];
    end else if (wr_two) begin
      flag_test       <= wdata[rt_mode_pkg::flag_test_bit];
      timeout_flag_en <= wdata[rt_mode_pkg::timeout_flag_bit];
      timeout_inh_en  <= wdata[rt_mode_pkg::timeout_inhibit_bit];
    end
  end

  // Terminal config: hardware set wins over a host write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      term_cfg <= rt_mode_pkg::terminal_config_reset;
    end else begin
      if (wr_en && sel_cfg) begin
        term_cfg <= wdata;
      end
      if (set_inh_a) begin
        term_cfg[rt_mode_pkg::inhibit_a_bit] <= 1'b1;
      end
      if (set_inh_b) begin
        term_cfg[rt_mode_pkg::inhibit_b_bit] <= 1'b1;
      end
    end
  end

  // Status word bits: timeout flag set wins over host clear
  always_ff @(posedge clk) begin
    if (rst) begin
      status_bits <= rt_mode_pkg::status_bits_reset;
    end else begin
      if (wr_en && sel_sw) begin
        status_bits <= wdata;
      end
      if (set_flag) begin
        status_bits[rt_mode_pkg::terminal_flag_bit] <= 1'b1;
      end
    end
  end

  // Permission to transmit; cut alone never blocks later frames
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_allow_a <= 1'b1;
      tx_allow_b <= 1'b1;
    end else begin
      tx_allow_a <= !term_cfg[rt_mode_pkg::inhibit_a_bit];
      tx_allow_b <= !term_cfg[rt_mode_pkg::inhibit_b_bit];
    end
  end

  // Flag sources merged
  assign flag_comb = status_bits[rt_mode_pkg::terminal_flag_bit] || flag_test;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0] two_view;
  logic [15:0] read_mux;

  // Unused bits 6-5 and 1-0 tie to zero
  assign two_view = {8'h00, busy_mode, 2'h0, flag_test,
                     timeout_flag_en, timeout_inh_en, 2'h0};
  assign read_mux = sel_two ? two_view :
                    sel_cfg ? term_cfg :
                    sel_sw  ? status_bits : 16'h0000;

  // Registered read data
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      rdata <= read_mux;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  tx_watchdog u_wd_a (
    .clk     (clk),
    .rst     (rst),
    .tx_busy (tx_busy_a),
    .tx_cut  (tx_cut_a),
    .timeout (timeout_a)
  );

  tx_watchdog u_wd_b (
    .clk     (clk),
    .rst     (rst),
    .tx_busy (tx_busy_b),
    .tx_cut  (tx_cut_b),
    .timeout (timeout_b)
  );

  busy_responder u_resp (
    .clk           (clk),
    .rst           (rst),
    .busy_mode     (busy_mode),
    .cmd_valid     (cmd_valid),
    .cmd_own       (cmd_own),
    .cmd_broadcast (cmd_broadcast),
    .flag_in       (flag_comb),
    .busy_in       (busy_in),
    .resp_start    (resp_start),
    .resp_busy     (resp_busy),
    .resp_flag     (resp_flag),
    .data_enable   (data_enable),
    .log_enable    (log_enable)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_entry;
    @(posedge clk) disable iff (rst) mr_rise |=> (busy_mode == $past(pin_sync[1]));
  endproperty
  a_entry: assert property (p_entry) else $error("entry wrong");

  property p_exit_write;
    @(posedge clk) disable iff (rst) (wr_exit && !mr_rise) |=> !busy_mode;
  endproperty
  a_exit_write: assert property (p_exit_write) else $error("write exit failed");

  property p_exit_start;
    @(posedge clk) disable iff (rst) (wr_start && !mr_rise) |=> !busy_mode;
  endproperty
  a_exit_start: assert property (p_exit_start) else $error("start exit failed");

  property p_exit_pin;
    @(posedge clk) disable iff (rst) (!pin_sync[1] && !mr_rise) |=> !busy_mode;
  endproperty
  a_exit_pin: assert property (p_exit_pin) else $error("pin exit failed");

  property p_busy_resp;
    @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_own && !cmd_broadcast && busy_mode) |=> resp_start && resp_busy && !data_enable;
  endproperty
  a_busy_resp: assert property (p_busy_resp) else $error("busy answer wrong");

  property p_no_log;
    @(posedge clk) disable iff (rst) (resp_start && $past(busy_mode)) |-> !log_enable;
  endproperty
  a_no_log: assert property (p_no_log) else $error("logging in busy mode");

  property p_reserved;
    @(posedge clk) disable iff (rst) $past(rd_en && sel_two) |-> (rdata[6:5] == 2'h0 && rdata[1:0] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_flag_test;
    @(posedge clk) disable iff (rst) (cmd_valid && cmd_own && !cmd_broadcast && flag_test) |=> resp_flag;
  endproperty
  a_flag_test: assert property (p_flag_test) else $error("flag test ignored");

  property p_inhibit_a;
    @(posedge clk) disable iff (rst) set_inh_a |=> ##1 !tx_allow_a;
  endproperty
  a_inhibit_a: assert property (p_inhibit_a) else $error("bus A not inhibited");

  property p_inhibit_b;
    @(posedge clk) disable iff (rst) set_inh_b |=> ##1 !tx_allow_b;
  endproperty
  a_inhibit_b: assert property (p_inhibit_b) else $error("bus B not inhibited");

  property p_flag_set;
    @(posedge clk) disable iff (rst) set_flag |=> flag_comb;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timeout flag missing");

  // Busy answers carry the status word alone
  property p_no_data;
    @(posedge clk) disable iff (rst) (resp_start && $past(busy_mode)) |-> !data_enable;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data words in busy mode");

  // Refused commands never start a response
  property p_no_answer;
    @(posedge clk) disable iff (rst) (cmd_valid && !(cmd_own && !cmd_broadcast)) |=> !resp_start;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer to foreign command");

  // Host flag reaches the status word on its own
  property p_flag_merge;
    @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_own && !cmd_broadcast && status_bits[rt_mode_pkg::terminal_flag_bit]) |=> resp_flag;
  endproperty
  a_flag_merge: assert property (p_flag_merge) else $error("host flag lost");

  // Status bit read back follows the mode itself
  property p_busy_read;
    @(posedge clk) disable iff (rst)
      $past(rd_en && sel_two) |-> (rdata[rt_mode_pkg::busy_mode_bit] == $past(busy_mode));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("mode status bit wrong");

  // Without inhibit enable a timeout must not block later frames
  property p_allow_kept_a;
    @(posedge clk) disable iff (rst)
      (timeout_a && !timeout_inh_en && !term_cfg[rt_mode_pkg::inhibit_a_bit] && !(wr_en && sel_cfg))
      |=> ##1 tx_allow_a;
  endproperty
  a_allow_kept_a: assert property (p_allow_kept_a) else $error("bus A blocked without inhibit");

  property p_allow_kept_b;
    @(posedge clk) disable iff (rst)
      (timeout_b && !timeout_inh_en && !term_cfg[rt_mode_pkg::inhibit_b_bit] && !(wr_en && sel_cfg))
      |=> ##1 tx_allow_b;
  endproperty
  a_allow_kept_b: assert property (p_allow_kept_b) else $error("bus B blocked without inhibit");

  // ----------------------------------------
  // Scenario coverage
  // ----------------------------------------
  c_busy_answer: cover property (@(posedge clk) disable iff (rst) resp_start && resp_busy);
  c_timeout_a:   cover property (@(posedge clk) disable iff (rst) set_inh_a);
  c_exit_write:  cover property (@(posedge clk) disable iff (rst) busy_mode ##1 wr_exit ##1 !busy_mode);
  c_flag_answer: cover property (@(posedge clk) disable iff (rst) resp_start && resp_flag && flag_test);
  c_pin_exit:    cover property (@(posedge clk) disable iff (rst) busy_mode ##1 !pin_sync[1] ##1 !busy_mode);
endmodule : rt_mode_ctrl
`default_nettype wire

/* sim/bus_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Bus controller model: issues commands
// ----------------------------------------
module bus_ctrl_model (
  input  wire logic clk,            // Device clock
  input  wire logic resp_start,     // Response start from terminal
  output var  logic cmd_valid,      // Valid command pulse
  output var  logic cmd_own,        // Own address matched
  output var  logic cmd_broadcast   // Broadcast command
);
  initial begin
    cmd_valid     = 1'b0;
    cmd_own       = 1'b0;
    cmd_broadcast = 1'b0;
  end

  // One command, then report whether an answer started in the next cycle
  task automatic issue(input logic own, input logic bcast, output logic answered);
    @(posedge clk);
    #1;
    cmd_valid     = 1'b1;
    cmd_own       = own;
    cmd_broadcast = bcast;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    // Qualifiers only count with the strobe, so scramble them afterwards
    cmd_own       = ~own;
    cmd_broadcast = ~bcast;
    answered      = resp_start;
  endtask : issue
endmodule : bus_ctrl_model
`default_nettype wire

/* sim/rt_mode_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none
module rt_1760_mode_and_tx_timeout_control_test;
  logic clk, rst, master_reset_n, mode_pin, wr_en, rd_en, busy_in, tx_busy_a, tx_busy_b;
  logic [15:0] addr, wdata, rdata;
  logic cmd_valid, cmd_own, cmd_broadcast, tx_cut_a, tx_cut_b, tx_allow_a, tx_allow_b;
  logic resp_start, resp_busy, resp_flag, data_enable, log_enable, ans;
  int   error_cnt, check_count, cycles;

  rt_mode_ctrl i_rt_mode_ctrl (.clk(clk), .rst(rst), .master_reset_n(master_reset_n), .mode_pin(mode_pin),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .cmd_valid(cmd_valid),
    .cmd_own(cmd_own), .cmd_broadcast(cmd_broadcast), .busy_in(busy_in), .tx_busy_a(tx_busy_a),
    .tx_busy_b(tx_busy_b), .tx_cut_a(tx_cut_a), .tx_cut_b(tx_cut_b), .tx_allow_a(tx_allow_a),
    .tx_allow_b(tx_allow_b), .resp_start(resp_start), .resp_busy(resp_busy), .resp_flag(resp_flag),
    .data_enable(data_enable), .log_enable(log_enable));
  bus_ctrl_model i_bus_ctrl_model (.clk(clk), .resp_start(resp_start), .cmd_valid(cmd_valid),
    .cmd_own(cmd_own), .cmd_broadcast(cmd_broadcast));

  // ----------------------------------------
  // Clock, hang guard, shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Four full watchdog runs dominate the run time
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 {wr_en, addr, wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1 {rd_en, addr} = {1'b1, a};
    @(posedge clk);
    #1 rd_en = 1'b0;
    chk(rdata, exp);
  endtask : rd

  // Command and compare the whole response
  task automatic cmd(input logic own, input logic bc, input logic [4:0] exp);
    i_bus_ctrl_model.issue(own, bc, ans);
    chk({11'h000, ans, resp_busy, resp_flag, data_enable, log_enable}, {11'h000, exp});
  endtask : cmd

  // Latch busy mode through a master reset pulse with the mode pin high
  task automatic enter_mode;
    mode_pin = 1'b1;
    master_reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 master_reset_n = 1'b1;
    repeat (6) @(posedge clk);
    rd(rt_mode_pkg::master_config_two_addr, 16'h0080);
  endtask : enter_mode

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_register;
    rd(rt_mode_pkg::master_config_two_addr, rt_mode_pkg::master_config_two_reset);
    wr(rt_mode_pkg::master_config_two_addr, 16'h00ff);
    rd(rt_mode_pkg::master_config_two_addr, 16'h001c);
    rd(16'h0123, 16'h0000);
    wr(rt_mode_pkg::master_config_two_addr, 16'h0000);
    $display("test register done");
  endtask : t_register

  task automatic t_busy_mode;
    enter_mode();
    cmd(1'b1, 1'b0, 5'b11000);
    cmd(1'b1, 1'b0, 5'b11000);
    cmd(1'b1, 1'b1, 5'b01000);
    cmd(1'b0, 1'b0, 5'b01000);
    wr(rt_mode_pkg::master_config_two_addr, 16'h0080);
    rd(rt_mode_pkg::master_config_two_addr, 16'h0000);
    cmd(1'b1, 1'b0, 5'b10011);
    enter_mode();
    wr(rt_mode_pkg::master_config_one_addr, 16'h0010);
    rd(rt_mode_pkg::master_config_two_addr, 16'h0000);
    enter_mode();
    mode_pin = 1'b0;
    repeat (5) @(posedge clk);
    rd(rt_mode_pkg::master_config_two_addr, 16'h0000);
    busy_in = 1'b1;
    cmd(1'b1, 1'b0, 5'b11011);
    busy_in = 1'b0;
    $display("test busy mode done");
  endtask : t_busy_mode

  task automatic t_flag;
    wr(rt_mode_pkg::master_config_two_addr, 16'h0010);
    cmd(1'b1, 1'b0, 5'b10111);
    wr(rt_mode_pkg::master_config_two_addr, 16'h0000);
    cmd(1'b1, 1'b0, 5'b10011);
    wr(rt_mode_pkg::status_bits_addr, 16'h0001);
    cmd(1'b1, 1'b0, 5'b10111);
    wr(rt_mode_pkg::status_bits_addr, 16'h0000);
    $display("test flag done");
  endtask : t_flag

  task automatic t_watchdog(input logic bus_b, input logic inh);
    int   n;
    logic cut;
    n = 0;
    wr(rt_mode_pkg::master_config_two_addr, inh ? 16'h000c : 16'h0008);
    @(posedge clk);
    #1 {tx_busy_b, tx_busy_a} = bus_b ? 2'b10 : 2'b01;
    do begin
      @(posedge clk);
      #1 n = n + 1;
      cut = bus_b ? tx_cut_b : tx_cut_a;
    end while (cut !== 1'b1 && n < 17000);
    chk(16'(n), 16'(rt_mode_pkg::tx_limit_cycles));
    {tx_busy_b, tx_busy_a} = 2'b00;
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, bus_b ? tx_allow_b : tx_allow_a}, {15'h0000, ~inh});
    rd(rt_mode_pkg::terminal_config_addr, inh ? (bus_b ? 16'h1000 : 16'h2000) : 16'h0000);
    rd(rt_mode_pkg::status_bits_addr, 16'h0001);
    wr(rt_mode_pkg::terminal_config_addr, 16'h0000);
    wr(rt_mode_pkg::status_bits_addr, 16'h0000);
    $display("test watchdog done");
  endtask : t_watchdog

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, master_reset_n, mode_pin, wr_en, rd_en, busy_in, tx_busy_a, tx_busy_b} = 8'b11000000;
    {addr, wdata, error_cnt, check_count, cycles} = '0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    chk({14'h0000, tx_allow_a, tx_allow_b}, 16'h0003);
    t_register();
    t_busy_mode();
    t_flag();
    t_watchdog(1'b0, 1'b1);
    t_watchdog(1'b1, 1'b1);
    t_watchdog(1'b0, 1'b0);
    t_watchdog(1'b1, 1'b0);
    close_out();
  end
endmodule : rt_1760_mode_and_tx_timeout_control_test
`default_nettype wire
